// *** hdl/dev_ctl_status.sv ***
// Notes on behaviour
// - bit 0 correctable reporting enable, reset 0
// - bit 1 non-fatal reporting enable, reset 0
// - bit 2 fatal reporting enable, reset 0
// - bit 3 unsupported request enable, reset 0
// - bit 4 relaxed ordering reads zero
// - bits 7:5 payload size, reset 000b
// - oversized payload write stores supported maximum
// - codes 128/256/512 bytes, maximum 512
// - bits 8, 9 no effect, read zero
// - bit 10 aux power enable, reset 0
// - bit 11 no-snoop reads zero
// - bits 14:12 hardwired zero, writes ignored
// - bit 16 correctable detected, write-one clears
// - bit 17 non-fatal detected, write-one clears
// - bit 18 fatal detected, write-one clears
// - bit 19 unsupported detected, write-one clears
// - flags record errors regardless of enables
// - bit 20 aux power present, reset 1
// - bit 21 transactions pending hardwired zero
`timescale 1ns/1ps
`default_nettype none

module dev_ctl_status
  import dev_ctl_pkg::*;
#(
  parameter logic [2:0] MAX_PAYLOAD_SUPPORTED = PAYLOAD_512
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  nrst,

  // axi4-lite write address channel
  input  wire logic [CFG_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,

  // axi4-lite write data channel
  input  wire logic [DATA_W-1:0]     s_axi_wdata,
  input  wire logic [STRB_W-1:0]     s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,

  // axi4-lite write response channel
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,

  // axi4-lite read address channel
  input  wire logic [CFG_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,

  // axi4-lite read data channel
  output logic [DATA_W-1:0]          s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,

  // one-cycle error events from the port logic
  input  wire logic                  corrErrEvent,
  input  wire logic                  nonFatalErrEvent,
  input  wire logic                  fatalErrEvent,
  input  wire logic                  unsupReqEvent,

  // auxiliary power sense pin
  input  wire logic                  auxPowerPin,

  // message requests to the message generator
  output logic                       corrMsgReq,
  output logic                       nonFatalMsgReq,
  output logic                       fatalMsgReq,
  output logic                       unsupMsgReq,

  // settings for the rest of the port
  output logic [2:0]                 maxPayloadSize,
  output logic                       auxPmEnable,
  output logic [NUM_ERR-1:0]         errReportEnable,
  output logic [NUM_ERR-1:0]         errDetected,
  output logic                       auxPowerPresent
);

  // write path state
  wr_state_e                 wrState;
  wr_state_e                 next_wrState;
  logic [CFG_ADDR_W-1:0]     wrAddr;
  logic [DATA_W-1:0]         wrData;
  logic [STRB_W-1:0]         wrStrb;
  logic                      awTake;
  logic                      wTake;
  logic [CFG_ADDR_W-1:0]     effAddr;
  logic [DATA_W-1:0]         effData;
  logic [STRB_W-1:0]         effStrb;
  logic                      doWrite;
  logic                      wrHit;

  // read path state
  rd_state_e                 rdState;
  logic                      arTake;
  logic                      rdHit;
  logic [DATA_W-1:0]         readWord;

  // error handling
  logic [NUM_ERR-1:0]        errEvent;
  logic [NUM_ERR-1:0]        errClear;
  logic [NUM_ERR-1:0]        msgReq;

  // protection bits carry no meaning here
  logic                      unusedProt;
  assign unusedProt = ^{s_axi_awprot, s_axi_arprot};

  // word-aligned address match
  function automatic logic addrHit(input logic [CFG_ADDR_W-1:0] a);
    return a[CFG_ADDR_W-1:2] == DEV_CTL_STS_OFFSET[CFG_ADDR_W-1:2];
  endfunction

  // limit a written payload code to the supported one
  function automatic logic [2:0] clampPayload(input logic [2:0] code);
    return (code > MAX_PAYLOAD_SUPPORTED) ? MAX_PAYLOAD_SUPPORTED : code;
  endfunction

  // ---------------------------------------------------------------
  // write channel handshake
  // ---------------------------------------------------------------

  // each half is accepted once while no response is pending
  assign s_axi_awready = (wrState == WR_IDLE) || (wrState == WR_HAVE_DATA);
  assign s_axi_wready  = (wrState == WR_IDLE) || (wrState == WR_HAVE_ADDR);
  assign awTake        = s_axi_awvalid && s_axi_awready;
  assign wTake         = s_axi_wvalid && s_axi_wready;
  assign s_axi_bvalid  = (wrState == WR_RESP);

  // next write state from the two halves
  always_comb begin
    next_wrState = wrState;
    case (wrState)
      WR_IDLE: begin
        if (awTake && wTake) begin
          next_wrState = WR_RESP;
        end else if (awTake) begin
          next_wrState = WR_HAVE_ADDR;
        end else if (wTake) begin
          next_wrState = WR_HAVE_DATA;
        end
      end
      WR_HAVE_ADDR: begin
        if (wTake) begin
          next_wrState = WR_RESP;
        end
      end
      WR_HAVE_DATA: begin
        if (awTake) begin
          next_wrState = WR_RESP;
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          next_wrState = WR_IDLE;
        end
      end
      default: begin
        next_wrState = WR_IDLE;
      end
    endcase
  end

  // write state register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wrState <= WR_IDLE;
    end else begin
      wrState <= next_wrState;
    end
  end

  // hold whichever half arrived first
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wrAddr <= '0;
      wrData <= '0;
      wrStrb <= '0;
    end else begin
      if (awTake) begin
        wrAddr <= s_axi_awaddr;
      end
      if (wTake) begin
        wrData <= s_axi_wdata;
        wrStrb <= s_axi_wstrb;
      end
    end
  end

  // the write lands on the edge that completes both halves
  assign effAddr = awTake ? s_axi_awaddr : wrAddr;
  assign effData = wTake ? s_axi_wdata : wrData;
  assign effStrb = wTake ? s_axi_wstrb : wrStrb;
  assign doWrite = (next_wrState == WR_RESP) && (wrState != WR_RESP);
  assign wrHit   = addrHit(effAddr);

  // write response code, unmapped words answer slverr
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_bresp <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ---------------------------------------------------------------
  // control half-word
  // ---------------------------------------------------------------

  // reporting enables, one per error class
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      errReportEnable <= ERR_EN_RESET;
    end else if (doWrite && wrHit && effStrb[LANE_CTL_LO]) begin
      errReportEnable <=
        effData[CTL_ERR_EN_LSB +: NUM_ERR];
    end
  end

  // payload size with clamping on write
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      maxPayloadSize <= PAYLOAD_RESET;
    end else if (doWrite && wrHit && effStrb[LANE_CTL_LO]) begin
      maxPayloadSize <=
        clampPayload(effData[CTL_PAYLOAD_MSB:CTL_PAYLOAD_LSB]);
    end
  end

  // aux power enable; lane 1 also covers tag and phantom bits
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      auxPmEnable <= AUX_PM_RESET;
    end else if (doWrite && wrHit && effStrb[LANE_CTL_HI]) begin
      auxPmEnable <= effData[CTL_AUX_PM];
    end
  end

  // ---------------------------------------------------------------
  // status half-word
  // ---------------------------------------------------------------

  assign errEvent[ERR_CORR]     = corrErrEvent;
  assign errEvent[ERR_NONFATAL] = nonFatalErrEvent;
  assign errEvent[ERR_FATAL]    = fatalErrEvent;
  assign errEvent[ERR_UNSUP]    = unsupReqEvent;

  // write-one-to-clear strobe per flag
  always_comb begin
    errClear = '0;
    if (doWrite && wrHit && effStrb[LANE_STS_LO]) begin
      errClear = effData[STS_ERR_LSB +: NUM_ERR];
    end
  end

  // sticky flags and message requests, one slice per error class
  genvar gi;
  generate
    for (gi = 0; gi < NUM_ERR; gi++) begin : g_err
      // a fresh error beats a clear in the same cycle
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          errDetected[gi] <= ERR_DET_RESET[gi];
        end else if (errEvent[gi]) begin
          errDetected[gi] <= 1'b1;
        end else if (errClear[gi]) begin
          errDetected[gi] <= 1'b0;
        end
      end

      // request a message only while reporting is enabled
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          msgReq[gi] <= 1'b0;
        end else begin
          msgReq[gi] <= errEvent[gi] && errReportEnable[gi];
        end
      end
    end
  endgenerate

  assign corrMsgReq     = msgReq[ERR_CORR];
  assign nonFatalMsgReq = msgReq[ERR_NONFATAL];
  assign fatalMsgReq    = msgReq[ERR_FATAL];
  assign unsupMsgReq    = msgReq[ERR_UNSUP];

  // aux power sense, settled before it is shown
  pin_sync3 #(
    .INIT     (AUX_DET_RESET)
  ) u_aux_sync (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .pinIn    (auxPowerPin),
    .levelOut (auxPowerPresent)
  );

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------

  // assemble the combined word; unlisted bits stay zero
  always_comb begin
    readWord = '0;
    readWord[CTL_ERR_EN_LSB +: NUM_ERR] = errReportEnable;
    readWord[CTL_RELAXED_ORD] = 1'b0;
    readWord[CTL_PAYLOAD_MSB:CTL_PAYLOAD_LSB] = maxPayloadSize;
    readWord[CTL_EXT_TAG] = 1'b0;
    readWord[CTL_PHANTOM] = 1'b0;
    readWord[CTL_AUX_PM] = auxPmEnable;
    readWord[CTL_NO_SNOOP] = 1'b0;
    readWord[CTL_RD_REQ_MSB:CTL_RD_REQ_LSB] = 3'h0;
    readWord[STS_ERR_LSB +: NUM_ERR] = errDetected;
    readWord[STS_AUX_DET] = auxPowerPresent;
    readWord[STS_TRANS_PEND] = 1'b0;
  end

  // one read at a time
  assign s_axi_arready = (rdState == RD_IDLE);
  assign arTake        = s_axi_arvalid && s_axi_arready;
  assign s_axi_rvalid  = (rdState == RD_RESP);
  assign rdHit         = addrHit(s_axi_araddr);

  // read state machine
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdState <= RD_IDLE;
    end else begin
      case (rdState)
        RD_IDLE: begin
          if (arTake) begin
            rdState <= RD_RESP;
          end
        end
        RD_RESP: begin
          if (s_axi_rready) begin
            rdState <= RD_IDLE;
          end
        end
        default: begin
          rdState <= RD_IDLE;
        end
      endcase
    end
  end

  // capture read data and code at the address edge
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (arTake) begin
      s_axi_rdata <= rdHit ? readWord : '0;
      s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end
  end

endmodule // dev_ctl_status

`default_nettype wire

// *** hdl/pin_sync3.sv ***
`timescale 1ns/1ps
`default_nettype none

module pin_sync3 #(
  parameter logic INIT = 1'b0
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic nrst,
  // asynchronous level in
  input  wire logic pinIn,
  // settled level out
  output logic      levelOut
);

  logic stage1;
  logic stage2;
  logic stage3;

  // three-stage chain; stage1 feeds only stage2
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // accept a change only when the late stages agree
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      levelOut <= INIT;
    end else if (stage2 == stage3) begin
      levelOut <= stage3;
    end
  end

endmodule // pin_sync3

`default_nettype wire

// *** inc/dev_ctl_pkg.sv ***
package dev_ctl_pkg;

  // bus geometry
  localparam int          CFG_ADDR_W         = 12;
  localparam int          DATA_W             = 32;
  localparam int          STRB_W             = DATA_W / 8;
  localparam logic [11:0] DEV_CTL_STS_OFFSET = 12'h0c8;

  // axi response codes
  localparam logic [1:0]  RESP_OKAY          = 2'h0;
  localparam logic [1:0]  RESP_SLVERR        = 2'h2;

  // byte lanes of the combined word
  localparam int          LANE_CTL_LO        = 0;
  localparam int          LANE_CTL_HI        = 1;
  localparam int          LANE_STS_LO        = 2;

  // control half-word fields
  localparam int          NUM_ERR            = 4;
  localparam int          CTL_ERR_EN_LSB     = 0;
  localparam int          CTL_RELAXED_ORD    = 4;
  localparam int          CTL_PAYLOAD_LSB    = 5;
  localparam int          CTL_PAYLOAD_MSB    = 7;
  localparam int          CTL_EXT_TAG        = 8;
  localparam int          CTL_PHANTOM        = 9;
  localparam int          CTL_AUX_PM         = 10;
  localparam int          CTL_NO_SNOOP       = 11;
  localparam int          CTL_RD_REQ_LSB     = 12;
  localparam int          CTL_RD_REQ_MSB     = 14;

  // status half-word fields
  localparam int          STS_ERR_LSB        = 16;
  localparam int          STS_AUX_DET        = 20;
  localparam int          STS_TRANS_PEND     = 21;

  // error index order inside the four-bit vectors
  localparam int          ERR_CORR           = 0;
  localparam int          ERR_NONFATAL       = 1;
  localparam int          ERR_FATAL          = 2;
  localparam int          ERR_UNSUP          = 3;

  // payload size codes
  localparam logic [2:0]  PAYLOAD_128        = 3'h0;
  localparam logic [2:0]  PAYLOAD_256        = 3'h1;
  localparam logic [2:0]  PAYLOAD_512        = 3'h2;

  // reset values
  localparam logic [2:0]  PAYLOAD_RESET      = PAYLOAD_128;
  localparam logic [3:0]  ERR_EN_RESET       = 4'h0;
  localparam logic [3:0]  ERR_DET_RESET      = 4'h0;
  localparam logic        AUX_PM_RESET       = 1'b0;
  localparam logic        AUX_DET_RESET      = 1'b1;

  // write channel states, gray along idle -> half -> resp
  typedef enum logic [1:0] {
    WR_IDLE      = 2'b00,
    WR_HAVE_ADDR = 2'b01,
    WR_RESP      = 2'b11,
    WR_HAVE_DATA = 2'b10
  } wr_state_e;

  // read channel states
  typedef enum logic {
    RD_IDLE = 1'b0,
    RD_RESP = 1'b1
  } rd_state_e;

endpackage

// *** test/dev_ctl_status_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module dev_ctl_status_props
  import dev_ctl_pkg::*;
#(
  parameter logic [2:0] MAX_PAYLOAD_SUPPORTED = PAYLOAD_512
) (
  // clock and reset
  input wire logic               ref_clk,
  input wire logic               nrst,
  // bus handshakes
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic [1:0]         s_axi_bresp,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire logic [DATA_W-1:0]  s_axi_rdata,
  // error events and requests
  input wire logic               corrErrEvent,
  input wire logic               nonFatalErrEvent,
  input wire logic               fatalErrEvent,
  input wire logic               unsupReqEvent,
  input wire logic               corrMsgReq,
  input wire logic               nonFatalMsgReq,
  input wire logic               fatalMsgReq,
  input wire logic               unsupMsgReq,
  // settings
  input wire logic [2:0]         maxPayloadSize,
  input wire logic [NUM_ERR-1:0] errReportEnable,
  input wire logic [NUM_ERR-1:0] errDetected
);
  logic [3:0] evt;
  logic [3:0] req;

  // events and requests gathered in enable order
  assign evt = {unsupReqEvent, fatalErrEvent, nonFatalErrEvent, corrErrEvent};
  assign req = {unsupMsgReq, fatalMsgReq, nonFatalMsgReq, corrMsgReq};

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_msg_gated: assert property (req == $past(evt & errReportEnable))
    else $error("message request not gated by enable");
  a_flag_sets: assert property (|evt |=>
    (errDetected & $past(evt)) == $past(evt))
    else $error("detected flag not set by event");
  a_payload_clamp: assert property (
    maxPayloadSize <= MAX_PAYLOAD_SUPPORTED)
    else $error("payload size above supported");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> s_axi_bvalid) else $error("write not answered");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  a_fixed_zero: assert property (
    s_axi_rvalid |-> (s_axi_rdata & 32'hffe0fb10) == 32'h0)
    else $error("fixed zero bits read nonzero");

  // main scenarios reached
  c_msg: cover property (|req);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  c_clamp: cover property (maxPayloadSize == MAX_PAYLOAD_SUPPORTED);
  c_stall: cover property (s_axi_bvalid && !s_axi_bready);
endmodule // dev_ctl_status_props

bind dev_ctl_status dev_ctl_status_props #(
  .MAX_PAYLOAD_SUPPORTED(MAX_PAYLOAD_SUPPORTED)
) props (.ref_clk(ref_clk), .nrst(nrst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .corrErrEvent(corrErrEvent),
  .nonFatalErrEvent(nonFatalErrEvent), .fatalErrEvent(fatalErrEvent),
  .unsupReqEvent(unsupReqEvent), .corrMsgReq(corrMsgReq),
  .nonFatalMsgReq(nonFatalMsgReq), .fatalMsgReq(fatalMsgReq),
  .unsupMsgReq(unsupMsgReq), .maxPayloadSize(maxPayloadSize),
  .errReportEnable(errReportEnable), .errDetected(errDetected));
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
  miscompares++; $display("BAD %s exp %h got %h", nm, ex, got); end end
module testbench;
  import dev_ctl_pkg::*;
  localparam logic [2:0]  MAXP = PAYLOAD_512;
  localparam logic [11:0] ADR  = DEV_CTL_STS_OFFSET;
  logic        ref_clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, auxPin, auxPmP, auxPresP;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, evt, req, enP, detP, mEn, mDet;
  logic [1:0]  bresp, rresp;
  logic [2:0]  payP, mPay;
  logic        mAux, mPres, slowResp;
  int          miscompares, checked, cyc, seedVal;

  dev_ctl_status #(.MAX_PAYLOAD_SUPPORTED(MAXP)) uut (
    .ref_clk(ref_clk), .nrst(nrst), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .corrErrEvent(evt[0]), .nonFatalErrEvent(evt[1]),
    .fatalErrEvent(evt[2]), .unsupReqEvent(evt[3]), .auxPowerPin(auxPin),
    .corrMsgReq(req[0]), .nonFatalMsgReq(req[1]), .fatalMsgReq(req[2]),
    .unsupMsgReq(req[3]), .maxPayloadSize(payP), .auxPmEnable(auxPmP),
    .errReportEnable(enP), .errDetected(detP), .auxPowerPresent(auxPresP));

  // clock and hang guard
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      print_verdict();
    end
  end

  // expected word from the bench model
  function automatic logic [31:0] expWord();
    return {10'h0, 1'b0, mPres, mDet, 5'h0, mAux, 2'h0, mPay, 1'b0, mEn};
  endfunction

  // model update for an accepted write
  task automatic mdl(input logic [31:0] d, input logic [3:0] s);
    if (s[0]) mEn = d[3:0];
    if (s[0]) mPay = (d[7:5] > MAXP) ? MAXP : d[7:5];
    if (s[1]) mAux = d[10];
    if (s[2]) mDet = mDet & ~d[19:16];
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= !slowResp;
    while (!(aw && w)) begin
      @(posedge ref_clk);
      if (awvalid && awready) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk); while (!bvalid);
    // late bready: response must stand until taken
    if (slowResp) begin
      bready <= 1'b1;
      @(posedge ref_clk);
    end
    `CHK("bresp", (a[11:2] == ADR[11:2]) ? RESP_OKAY : RESP_SLVERR, bresp)
    bready <= 1'b0;
    if (a[11:2] == ADR[11:2]) mdl(d, s);
  endtask

  task automatic rd(input logic [11:0] a);
    logic ok;
    logic [31:0] ew;
    ok = (a[11:2] == ADR[11:2]);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= !slowResp;
    do @(posedge ref_clk); while (!(arvalid && arready));
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (!rvalid);
    // late rready: data must stand until taken
    if (slowResp) begin
      rready <= 1'b1;
      @(posedge ref_clk);
    end
    ew = ok ? expWord() : 32'h0;
    `CHK("word", ew, rdata)
    `CHK("rresp", ok ? RESP_OKAY : RESP_SLVERR, rresp)
    `CHK("enables", mEn, enP)
    `CHK("payload", mPay, payP)
    `CHK("auxpm", mAux, auxPmP)
    `CHK("auxpresent", mPres, auxPresP)
    rready <= 1'b0;
  endtask

  // one-cycle events, then request and flag check
  task automatic fire(input logic [3:0] e);
    @(posedge ref_clk);
    evt <= e;
    @(posedge ref_clk);
    evt <= 4'h0;
    #1;
    `CHK("msgreq", e & mEn, req)
    mDet = mDet | e;
    `CHK("detected", mDet, detP)
  endtask

  task automatic print_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // main sequence
  initial begin
    {ref_clk, nrst, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb, evt} = '0;
    auxPin = 1'b1;
    {mEn, mDet, mPay, mAux} = '0;
    slowResp = 1'b0;
    mPres = 1'b1;
    seedVal = $urandom(52);
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(ADR);
    $display("test reset values done");
    for (int c = 0; c < 8; c++) begin
      wr(ADR, 32'(c) << 5, 4'h1);
      rd(ADR);
    end
    $display("test payload codes done");
    wr(ADR, 32'h0000000f, 4'h1);
    for (int i = 0; i < 4; i++) fire(4'h1 << i);
    fire(4'hf);
    wr(ADR, 32'h0, 4'h1);
    fire(4'hf);
    rd(ADR);
    $display("test error events done");
    wr(ADR, 32'h0, 4'h4);
    rd(ADR);
    wr(ADR, 32'hffffffff, 4'h3);
    rd(ADR);
    wr(ADR, 32'h000a0000, 4'h4);
    rd(ADR);
    // events land on the same edge as a write-one clear
    fork
      wr(ADR, 32'h000f0000, 4'h4);
      begin
        @(posedge ref_clk);
        evt <= 4'hf;
        @(posedge ref_clk);
        evt <= 4'h0;
      end
    join
    mDet = 4'hf;
    rd(ADR);
    $display("test write one clear done");
    wr(12'h0cc, 32'hffffffff, 4'hf);
    rd(12'h0cc);
    rd(12'h0c4);
    rd(ADR);
    $display("test unmapped done");
    repeat (16) begin
      slowResp = 1'($urandom);
      fire(4'($urandom));
      wr(ADR, $urandom, 4'($urandom));
      rd(ADR);
    end
    $display("test random traffic done");
    auxPin <= 1'b0;
    repeat (8) @(posedge ref_clk);
    mPres = 1'b0;
    rd(ADR);
    auxPin <= 1'b1;
    repeat (8) @(posedge ref_clk);
    mPres = 1'b1;
    rd(ADR);
    $display("test aux power done");
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
